// [logic/rcb_defines.svh]
// Constants for the registered command buffer: widths, parity masks, reset values.
// Assumes data bit 0 carries input 1 and bit 27 carries input 28.
`ifndef RCB_DEFINES_SVH
`define RCB_DEFINES_SVH

`define RCB_WIDTH        28
`define RCB_RANK_WIDTH   4

// Parity coverage for pinout configuration A (strap low)
`define RCB_MASK_A       28'hFFF_0F5F
// Parity coverage for pinout configuration B (strap high)
`define RCB_MASK_B       28'hFAF_0FFF

`define RCB_RESET_OUT    28'h000_0000
`define RCB_RESET_RANK   4'h0
`define RCB_RESET_FLAG_N 1'h1

`endif

// [logic/rcb_pkg.sv]
// Types for the registered command buffer.
// Assumes rcb_defines.svh is on the include path.
`include "rcb_defines.svh"

package rcb_pkg;

	typedef enum logic [1:0] {
		RCB_FLAG_CLEAR,
		RCB_FLAG_ERR,
		RCB_FLAG_HOLD
	} rcb_flag_t;

	typedef struct packed {
		logic [`RCB_WIDTH-1:0]      cap;
		logic [`RCB_WIDTH-1:0]      outq;
		logic [`RCB_RANK_WIDTH-1:0] rank_ctl;
		logic                       err_pend;
		rcb_flag_t                  flag_st;
		logic                       flag_n;
		logic                       cfg_b;
		logic                       standby_prev;
	} rcb_state_t;

endpackage

// [logic/rcb_masked_parity.sv]
// Reduction parity over the bits of a word selected by a mask.
// Assumes a purely combinational use; no state.
`timescale 1ns/1ps
`default_nettype none

module rcb_masked_parity #(
	parameter int WIDTH = 28
) (
	input  wire logic [WIDTH-1:0] data,
	input  wire logic [WIDTH-1:0] mask,
	output logic                  parity
);

	always_comb begin
		parity = ^(data & mask);
	end

endmodule

`default_nettype wire

// [logic/rcb_buffer.sv]
// Registered 28-bit command buffer with 1:2 outputs, delayed-parity check and chip-select gating.
// Assumes one clock (clk_sys) standing for the differential crossing, synchronous active-low reset,
// and a pinout strap that is held static while running.
//
// Operation
// - Each of 28 registered inputs drives two identical output copies.
// - All data inputs are captured on the rising edge of the clock.
// - Strap low: parity covers inputs 1-5, 7, 9-12, 17-28 and parity bit.
// - Strap high: parity covers inputs 1-12, 17-20, 22, 24-28 and parity bit.
// - Even ones count is valid; an odd count pulls the error flag low.
// - Parity bit arrives one cycle late and pairs with the previous word.
// - Error flag for a word appears two clocks after that word's capture.
// - A single error keeps the flag low at least two clocks unless reset.
// - Consecutive errors keep the flag low for as long as they persist.
// - Error before low power holds flag through low power plus two clocks; an error still pending when both selects go high is dropped.
// - Rank clock enable, termination and select inputs are outside parity.
// - Strap low selects configuration A; strap high selects configuration B.
// - Reset clears every register and drives outputs low, except the flag and the sampled strap.
// - After reset, outputs stay low without glitches while inputs stay low.
// - Gating enable with both selects high freezes the registered outputs.
// - Both selects high freeze the error flag; otherwise it acts normally.
// - Reset overrides gating, forcing outputs low and releasing the flag high.
`timescale 1ns/1ps
`default_nettype none

module rcb_buffer
	import rcb_pkg::*;
(
	input  wire logic                       clk_sys,
	input  wire logic                       rstn,
	input  wire logic                       pinout_config_b,
	input  wire logic                       chip_select_gating_enable,
	input  wire logic                       rank0_select_n,
	input  wire logic                       rank1_select_n,
	input  wire logic                       rank0_clock_enable_in,
	input  wire logic                       rank1_clock_enable_in,
	input  wire logic                       rank0_termination_ctl_in,
	input  wire logic                       rank1_termination_ctl_in,
	input  wire logic [`RCB_WIDTH-1:0]      data_in,
	input  wire logic                       parity_bit_input,
	output logic      [`RCB_WIDTH-1:0]      registered_outputs_a,
	output logic      [`RCB_WIDTH-1:0]      registered_outputs_b,
	output logic      [`RCB_RANK_WIDTH-1:0] rank_ctl_out_a,
	output logic      [`RCB_RANK_WIDTH-1:0] rank_ctl_out_b,
	output logic                            parity_error_flag_n,
	output logic                            parity_error_flag_oe,
	output logic                            low_power_state
);

	rcb_state_t            st_reg;
	rcb_state_t            st_next;
	logic [`RCB_WIDTH-1:0] parity_mask;
	logic                  word_parity;
	logic                  word_err;
	logic                  gate_active;
	logic                  flag_frozen;
	logic                  standby_exit;

	// Strap is sampled into a register at reset so a stray wiggle later cannot
	// change which bits are checked in the middle of a burst of commands.
	always_comb begin
		parity_mask = st_reg.cfg_b ? `RCB_MASK_B : `RCB_MASK_A;
	end

	// Only the captured data word feeds the checker; rank controls never reach it.
	rcb_masked_parity #(
		.WIDTH (`RCB_WIDTH)
	) u_parity (
		.data   (st_reg.cap),
		.mask   (parity_mask),
		.parity (word_parity)
	);

	always_comb begin
		word_err    = word_parity ^ parity_bit_input;
		gate_active = chip_select_gating_enable & rank0_select_n & rank1_select_n;
		flag_frozen = rank0_select_n & rank1_select_n;
		standby_exit = st_reg.standby_prev & ~flag_frozen;
	end

	always_comb begin
		st_next = st_reg;
		if (!rstn) begin
			// Reset wins over any gating condition
			st_next          = '0;
			st_next.outq     = `RCB_RESET_OUT;
			st_next.rank_ctl = `RCB_RESET_RANK;
			st_next.flag_st  = RCB_FLAG_CLEAR;
			st_next.flag_n   = `RCB_RESET_FLAG_N;
			st_next.cfg_b    = pinout_config_b;
		end else begin
			st_next.cap      = data_in;
			st_next.err_pend = word_err;
			st_next.standby_prev = flag_frozen;
			// Clock enable and termination must follow even in gated standby,
			// otherwise the memory could not be put into power-down.
			st_next.rank_ctl = {rank1_termination_ctl_in, rank0_termination_ctl_in,
				rank1_clock_enable_in, rank0_clock_enable_in};
			if (!gate_active) begin
				st_next.outq = st_reg.cap;
			end
			if (!flag_frozen) begin
				case (st_reg.flag_st)
					RCB_FLAG_CLEAR: begin
						if (st_reg.err_pend) begin
							st_next.flag_st = RCB_FLAG_ERR;
						end
					end
					RCB_FLAG_ERR: begin
						if (st_reg.err_pend) begin
							st_next.flag_st = RCB_FLAG_ERR;
						end else if (standby_exit) begin
							// Restart the two-clock tail once standby ends
							st_next.flag_st = RCB_FLAG_ERR;
						end else begin
							st_next.flag_st = RCB_FLAG_HOLD;
						end
					end
					RCB_FLAG_HOLD: begin
						if (st_reg.err_pend || standby_exit) begin
							st_next.flag_st = RCB_FLAG_ERR;
						end else begin
							st_next.flag_st = RCB_FLAG_CLEAR;
						end
					end
					default: begin
						st_next.flag_st = RCB_FLAG_CLEAR;
					end
				endcase
				st_next.flag_n = (st_next.flag_st == RCB_FLAG_CLEAR);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		st_reg <= st_next;
	end

	// All outputs come straight from flops (flag drive enable through one inverter), so nothing can glitch after reset
	always_comb begin
		registered_outputs_a = st_reg.outq;
		registered_outputs_b = st_reg.outq;
		rank_ctl_out_a       = st_reg.rank_ctl;
		rank_ctl_out_b       = st_reg.rank_ctl;
		parity_error_flag_n  = st_reg.flag_n;
		parity_error_flag_oe = ~st_reg.flag_n;
		low_power_state      = st_reg.standby_prev;
	end

	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking

	default disable iff (!rstn);

	a_copies_match: assert property (
		registered_outputs_a == registered_outputs_b
	) else $error("output copies differ");

	a_capture_latency: assert property (
		rstn && $past(rstn) && !gate_active |=> registered_outputs_a == $past(data_in, 2)
	) else $error("ungated output is not the input captured one clock earlier");

	a_capture_edge: assert property (
		$past(rstn) |-> st_reg.cap == $past(data_in)
	) else $error("data not captured on the clock edge");

	a_gate_freeze: assert property (
		gate_active |=> $stable(registered_outputs_a)
	) else $error("gated outputs changed");

	a_gate_release: assert property (
		!chip_select_gating_enable && $past(rstn) |=> registered_outputs_a == $past(st_reg.cap)
	) else $error("outputs frozen while gating disabled");

	a_err_two_clocks: assert property (
		word_err ##1 !flag_frozen |=> !parity_error_flag_n
	) else $error("error flag not low two clocks after a bad word");

	a_no_false_err: assert property (
		!st_reg.err_pend && st_reg.flag_st == RCB_FLAG_CLEAR && !flag_frozen |=> parity_error_flag_n
	) else $error("error flag low without parity error");

	a_err_min_hold: assert property (
		$fell(parity_error_flag_n) |=> !parity_error_flag_n
	) else $error("error flag low for less than two clocks");

	a_err_persist: assert property (
		st_reg.err_pend && !flag_frozen |=> !parity_error_flag_n
	) else $error("flag released while errors persist");

	a_standby_tail: assert property (
		standby_exit && !parity_error_flag_n |=> !parity_error_flag_n [*2]
	) else $error("flag not held two clocks after low power");

	a_flag_frozen: assert property (
		flag_frozen |=> $stable(parity_error_flag_n)
	) else $error("error flag changed while both selects high");

	a_mask_select: assert property (
		$past(rstn) |-> parity_mask == (pinout_config_b ? `RCB_MASK_B : `RCB_MASK_A)
	) else $error("parity mask does not follow the strap");

	a_rank_excluded: assert property (
		$past(rstn) && $stable(st_reg.cap) && $stable(parity_mask) |-> $stable(word_parity)
	) else $error("parity depends on something besides the data word");

	// Rank controls pass through one register and are never frozen by gating
	a_rank_follow: assert property (
		$past(rstn) |-> rank_ctl_out_a == $past({rank1_termination_ctl_in, rank0_termination_ctl_in,
			rank1_clock_enable_in, rank0_clock_enable_in}) && rank_ctl_out_b == rank_ctl_out_a
	) else $error("rank controls not passed through one register");

	a_flag_drive: assert property (
		parity_error_flag_oe == !parity_error_flag_n
	) else $error("flag drive enable does not match the flag");

	a_reset_clears: assert property (
		disable iff (1'b0)
		!rstn |=> registered_outputs_a == `RCB_RESET_OUT && rank_ctl_out_a == `RCB_RESET_RANK
			&& parity_error_flag_n && !parity_error_flag_oe
	) else $error("reset did not clear outputs and release flag");

	a_reset_quiet: assert property (
		disable iff (1'b0)
		!rstn ##1 (rstn && data_in == `RCB_RESET_OUT) [*2] |-> registered_outputs_a == `RCB_RESET_OUT
	) else $error("outputs moved after reset with inputs low");

	c_single_error: cover property (
		parity_error_flag_n ##1 !parity_error_flag_n ##1 !parity_error_flag_n ##1 parity_error_flag_n
	);

	c_error_burst: cover property (
		st_reg.err_pend [*3] ##1 !parity_error_flag_n
	);

	c_standby_with_error: cover property (
		!parity_error_flag_n && flag_frozen [*3] ##1 standby_exit
	);

	c_gated_outputs: cover property (
		gate_active [*4] ##1 !gate_active
	);

endmodule

`default_nettype wire

// [tb/rcb_ctrl_model.sv]
// Controller-side model: presents the word and its even parity one clock later.
// Assumes the bench changes word and corrupt at the falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "rcb_defines.svh"

module rcb_ctrl_model (
	input  wire logic                  clk_sys,
	input  wire logic                  cfg_b,
	input  wire logic [`RCB_WIDTH-1:0] word,
	input  wire logic                  corrupt,
	output logic      [`RCB_WIDTH-1:0] data_in,
	output logic                       parity_bit_input
);
	assign data_in = word;
	// Corrupt flips the late parity bit to fake a bus error
	always @(posedge clk_sys) begin
		parity_bit_input <= ^(word & (cfg_b ? `RCB_MASK_B : `RCB_MASK_A)) ^ corrupt;
	end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the registered command buffer.
// Assumes inputs change at the falling edge; both strap settings are run.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic        clk_sys = 0, rstn = 0, cfg = 0, gate_en = 0, sel0_n = 0, sel1_n = 0, corrupt = 0;
	logic [27:0] word = 28'h000_0000, data_in, out_a, out_b;
	logic [3:0]  rk_a, rk_b;
	logic        par, flag_n, flag_oe, lps;
	int          miscompares = 0, total_checks = 0, cycles = 0;
	logic [27:0] w[16] = '{28'h000_00A0, 28'h050_F000, 28'hFFF_FFFF, 28'h123_4567, 28'h050_0000, 28'h000_0001,
		28'h800_0000, 28'h555_5555, 28'hAAA_AAAA, 28'h000_0000, 28'h0F0_0F0F, 28'h765_4321,
		28'h3C3_C3C3, 28'h3C3_C3C3, 28'h3C3_C3C3, 28'h3C3_C3C3};
	logic [15:0] bad = 16'h0262;

	rcb_ctrl_model i_rcb_ctrl_model (.clk_sys(clk_sys), .cfg_b(cfg), .word(word), .corrupt(corrupt),
		.data_in(data_in), .parity_bit_input(par));
	rcb_buffer i_rcb_buffer (.clk_sys(clk_sys), .rstn(rstn), .pinout_config_b(cfg),
		.chip_select_gating_enable(gate_en), .rank0_select_n(sel0_n), .rank1_select_n(sel1_n),
		.rank0_clock_enable_in(word[0]), .rank1_clock_enable_in(word[1]),
		.rank0_termination_ctl_in(word[2]), .rank1_termination_ctl_in(word[3]),
		.data_in(data_in), .parity_bit_input(par), .registered_outputs_a(out_a),
		.registered_outputs_b(out_b), .rank_ctl_out_a(rk_a), .rank_ctl_out_b(rk_b),
		.parity_error_flag_n(flag_n), .parity_error_flag_oe(flag_oe), .low_power_state(lps));

	always #25 clk_sys = ~clk_sys;

	// A run of about 90 cycles; the ceiling leaves wide margin
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 1000) begin
			miscompares++;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		for (int c = 0; c < 2; c++) begin
			cfg = c[0];
			rstn = 0;
			word = 28'h000_0000;
			gate_en = 0;
			sel0_n = 0;
			sel1_n = 0;
			corrupt = 0;
			repeat (16) @(negedge clk_sys);
			chk(out_a, 0);
			chk(rk_b, 0);
			chk(flag_n, 1);
			chk(flag_oe, 0);
			rstn = 1;
			// Two idle low words after release: outputs must not move
			repeat (2) @(negedge clk_sys);
			chk(out_b, 0);
			chk(out_a, 0);
			// Outputs two falling edges after drive; flag three and four after a bad word
			for (int i = 0; i < 16; i++) begin
				if (i >= 2) begin
					chk(out_a, w[i-2]);
					chk(out_b, w[i-2]);
					chk(rk_a, w[i-1][3:0]);
					chk(rk_b, w[i-1][3:0]);
					chk(lps, 0);
				end
				if (i >= 4) begin
					chk(flag_n, !(bad[i-3] | bad[i-4]));
					chk(flag_oe, bad[i-3] | bad[i-4]);
				end
				word = w[i];
				corrupt = bad[i];
				@(negedge clk_sys);
			end
			word = 28'h0FF_FF00;
			corrupt = 1;
			@(negedge clk_sys);
			word = 28'h111_1111;
			corrupt = 0;
			repeat (2) @(negedge clk_sys);
			chk(flag_n, 0);
			gate_en = 1;
			sel0_n = 1;
			sel1_n = 1;
			word = 28'h222_2222;
			repeat (4) @(negedge clk_sys);
			chk(out_a, 28'h111_1111);
			chk(lps, 1);
			chk(flag_n, 0);
			gate_en = 0;
			repeat (2) @(negedge clk_sys);
			chk(out_b, 28'h222_2222);
			chk(flag_n, 0);
			sel0_n = 0;
			@(negedge clk_sys);
			chk(flag_n, 0);
		end
		end_sim();
	end
endmodule
`default_nettype wire
